// ### design/wam_wide_addr.sv
// Wide addressing extension of the processor: 15-bit program counter,
// extend and prior-mode flags, mode instructions, store-return and
// prior-mode sense, with an Avalon-MM register slave.
// Assumes the core pulses its execute, interrupt and clear strobes for
// one cycle and waits for o_instr_done on every decoded instruction.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Program counter becomes fifteen bits when the memory expansion is fitted.
// - High counter bit drives the address MSB line for nonzero sectors.
// - In extend mode the indirect word index position is an address bit.
// - Extend mode allows one index step, instruction bit 2, applied last.
// - Mode instructions set or clear extend; a program interrupt sets it.
// - Interrupt copies current extend mode into the prior-mode flag.
// - Prior-mode flag clears on non-extend interrupt and on master clear.
// - Extend-mode store-return saves fifteen counter bits, keeps word bit 1.
// - Enter instruction sets extend mode, taking one 1.7 us instruction time.
// - Leave takes effect only after a jump executes in the existing mode.
// - Prior-mode sense skips when the flag is set; takes 3.4 us.
module wam_wide_addr #(
    parameter logic [15:0] ENTER_CODE = wam_pkg::ENTER_CODE_DEF,
    parameter logic [15:0] LEAVE_CODE = wam_pkg::LEAVE_CODE_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Avalon-MM slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Core strobes
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr_word,
    input wire logic i_int_taken,
    input wire logic i_master_clear,
    input wire logic i_pc_load,
    input wire logic [14:0] i_pc_value,
    input wire logic i_pc_incr,
    input wire logic [15:0] i_ret_old_word,
    // Address formation request
    input wire logic i_ea_req,
    input wire logic i_ea_from_indirect,
    input wire logic [15:0] i_ea_indirect_word,
    input wire logic [14:0] i_ea_index_value,
    // Results
    output logic [14:0] o_pc,
    output logic o_pc_high_extension_bit,
    output logic o_extend_mode,
    output logic o_prior_mode_flag,
    output logic [14:0] o_ea,
    output logic o_memory_address_msb_line,
    output logic o_ea_valid,
    output logic [15:0] o_ret_store_word,
    output logic o_instr_done,
    output logic o_skip
);
    logic fitted_q;
    logic extend_q;
    logic prior_q;
    logic leave_pend_q;
    logic [14:0] pc_q;
    logic [14:0] pc_d;
    logic [14:0] ea_q;
    logic [14:0] ea_d;
    logic ea_valid_q;
    logic [15:0] ret_word_q;
    logic done_q;
    logic skip_q;
    logic skip_pend_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    wam_pkg::wam_state_e state_q;
    logic timer_start;
    logic [wam_pkg::CNT_W-1:0] timer_cycles;
    logic timer_expired;
    logic [3:0] opc;
    logic is_enter;
    logic is_leave;
    logic is_sense;
    logic is_jump;
    logic is_store_ret;
    logic bus_wr;
    logic bus_rd;

    assign opc = i_instr_word[wam_pkg::IW_OPC_HI:wam_pkg::IW_OPC_LO];
    assign is_enter = (i_instr_word == ENTER_CODE);
    assign is_leave = (i_instr_word == LEAVE_CODE);
    assign is_sense = (opc == wam_pkg::OPC_SENSE)
        && (i_instr_word[9:0] == wam_pkg::SENSE_PRIOR_FN);
    assign is_jump = (opc == wam_pkg::OPC_JUMP);
    assign is_store_ret = (opc == wam_pkg::OPC_STORE_RET);
    assign bus_wr = i_avs_write && !wait_q;
    assign bus_rd = i_avs_read && wait_q;

    // Avalon handshake: waitrequest drops for exactly one cycle per access
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            wait_q <= 1'b1;
        else
            wait_q <= !((i_avs_read || i_avs_write) && wait_q);
    end

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (i_avs_address)
            wam_pkg::OFS_CTRL:
                rdata_d[wam_pkg::CTRL_FITTED_BIT] = fitted_q;
            wam_pkg::OFS_STATUS:
            begin
                rdata_d[wam_pkg::STAT_EXTEND_BIT] = extend_q;
                rdata_d[wam_pkg::STAT_PRIOR_BIT] = prior_q;
                rdata_d[wam_pkg::STAT_LEAVE_BIT] = leave_pend_q;
                rdata_d[wam_pkg::STAT_BUSY_BIT] = (state_q != wam_pkg::WAM_ST_IDLE);
            end
            wam_pkg::OFS_PC:
                rdata_d[14:0] = pc_q;
            default:
                rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            rdata_q <= 32'h0000_0000;
        else if (bus_rd)
            rdata_q <= rdata_d;
    end

    // Expansion-fitted control; without it the counter stays at 14 bits
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            fitted_q <= wam_pkg::CTRL_FITTED_RST;
        else if (bus_wr && i_avs_address == wam_pkg::OFS_CTRL)
            fitted_q <= i_avs_writedata[wam_pkg::CTRL_FITTED_BIT];
    end

    // Program counter
    always_comb
    begin
        if (i_pc_load)
            pc_d = i_pc_value;
        else if (i_pc_incr)
            pc_d = 15'(pc_q + 15'h0001);
        else
            pc_d = pc_q;
        if (!fitted_q)
            pc_d[14] = 1'b0;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            pc_q <= 15'h0000;
        else
            pc_q <= pc_d;
    end

    // Extend mode; interrupt wins over any instruction in the same cycle
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            extend_q <= 1'b0;
            leave_pend_q <= 1'b0;
        end
        else if (i_int_taken)
        begin
            extend_q <= 1'b1;
            leave_pend_q <= 1'b0;
        end
        else if (i_instr_valid)
        begin
            if (is_enter)
            begin
                extend_q <= 1'b1;
                leave_pend_q <= 1'b0;
            end
            else if (is_leave)
                leave_pend_q <= 1'b1;
            else if (is_jump && leave_pend_q)
            begin
                // The jump itself still ran in extend mode
                extend_q <= 1'b0;
                leave_pend_q <= 1'b0;
            end
        end
    end

    // Prior-mode flag
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            prior_q <= 1'b0;
        else if (i_int_taken)
            prior_q <= extend_q;
        else if (i_master_clear)
            prior_q <= 1'b0;
    end

    // Store-return word
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            ret_word_q <= 16'h0000;
        else if (i_instr_valid && is_store_ret)
        begin
            if (extend_q)
                ret_word_q <= {i_ret_old_word[15], pc_q};
            else
                ret_word_q <= {i_ret_old_word[15:14], pc_q[13:0]};
        end
    end

    wam_ea_former u_ea (
        .i_extend(extend_q),
        .i_fitted(fitted_q),
        .i_pc(pc_q),
        .i_instr_word(i_instr_word),
        .i_from_indirect(i_ea_from_indirect),
        .i_indirect_word(i_ea_indirect_word),
        .i_index_value(i_ea_index_value),
        .o_ea(ea_d)
    );

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ea_q <= 15'h0000;
            ea_valid_q <= 1'b0;
        end
        else
        begin
            ea_valid_q <= i_ea_req;
            if (i_ea_req)
                ea_q <= ea_d;
        end
    end

    // Instruction timing: only the enter and sense instructions are stretched
    assign timer_start = i_instr_valid && (state_q == wam_pkg::WAM_ST_IDLE)
        && (is_enter || is_sense);
    assign timer_cycles = is_sense ? wam_pkg::SENSE_CYCLES : wam_pkg::ENTER_CYCLES;

    wam_cycle_timer u_timer (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_start(timer_start),
        .i_cycles(timer_cycles),
        .o_expired(timer_expired)
    );

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            state_q <= wam_pkg::WAM_ST_IDLE;
        else
        begin
            case (state_q)
                wam_pkg::WAM_ST_IDLE:
                    if (i_instr_valid)
                        state_q <= timer_start ? wam_pkg::WAM_ST_BUSY : wam_pkg::WAM_ST_FINISH;
                wam_pkg::WAM_ST_BUSY:
                    if (timer_expired)
                        state_q <= wam_pkg::WAM_ST_FINISH;
                wam_pkg::WAM_ST_FINISH:
                    state_q <= wam_pkg::WAM_ST_IDLE;
                default:
                    state_q <= wam_pkg::WAM_ST_IDLE;
            endcase
        end
    end

    // Skip decision sampled at decode so a later interrupt cannot change it
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            skip_pend_q <= 1'b0;
        else if (i_instr_valid && state_q == wam_pkg::WAM_ST_IDLE)
            skip_pend_q <= is_sense && prior_q;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            done_q <= 1'b0;
            skip_q <= 1'b0;
        end
        else
        begin
            done_q <= (state_q == wam_pkg::WAM_ST_FINISH);
            skip_q <= (state_q == wam_pkg::WAM_ST_FINISH) && skip_pend_q;
        end
    end

    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_pc = pc_q;
    assign o_pc_high_extension_bit = pc_q[14];
    assign o_extend_mode = extend_q;
    assign o_prior_mode_flag = prior_q;
    assign o_ea = ea_q;
    assign o_memory_address_msb_line = ea_q[14];
    assign o_ea_valid = ea_valid_q;
    assign o_ret_store_word = ret_word_q;
    assign o_instr_done = done_q;
    assign o_skip = skip_q;
endmodule // wam_wide_addr
`default_nettype wire

// ### design/wam_pkg.sv
// Constants for the wide addressing extension: bus map, field positions,
// opcodes, reset values and instruction timing.
// Assumes a 50 MHz core clock and 16-bit instruction words, bit 1 = MSB.
package wam_pkg;

    localparam int CLK_MHZ = 50;

    // Register map, byte addresses on the 32-bit slave
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_PC = 4'h8;

    // Control register fields and reset value
    localparam int CTRL_FITTED_BIT = 0;
    localparam logic CTRL_FITTED_RST = 1'b1;

    // Status register fields
    localparam int STAT_EXTEND_BIT = 0;
    localparam int STAT_PRIOR_BIT = 1;
    localparam int STAT_LEAVE_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;

    // Instruction word fields (printed bit n sits at index 16-n)
    localparam int IW_INDIRECT_BIT = 15;
    localparam int IW_INDEX_BIT = 14;
    localparam int IW_SECTOR_BIT = 9;
    localparam int IW_OPC_HI = 13;
    localparam int IW_OPC_LO = 10;
    localparam int SECTOR_LSB = 9;

    // Memory reference opcodes in word bits 13..10
    localparam logic [3:0] OPC_JUMP = 4'h1;
    localparam logic [3:0] OPC_STORE_RET = 4'h8;
    localparam logic [3:0] OPC_SENSE = 4'hc;

    // Function field of the prior-mode sense (octal 0120)
    localparam logic [9:0] SENSE_PRIOR_FN = 10'h050;

    // Default generic encodings; not printed, so overridable at the top
    localparam logic [15:0] ENTER_CODE_DEF = 16'h0013;
    localparam logic [15:0] LEAVE_CODE_DEF = 16'h0009;

    // Instruction times
    localparam int ENTER_TIME_NS = 1700;
    localparam int SENSE_TIME_NS = 3400;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] ENTER_CYCLES = CNT_W'((ENTER_TIME_NS * CLK_MHZ) / 1000);
    localparam logic [CNT_W-1:0] SENSE_CYCLES = CNT_W'((SENSE_TIME_NS * CLK_MHZ) / 1000);

    typedef enum logic [1:0] {
        WAM_ST_IDLE = 2'b00,
        WAM_ST_BUSY = 2'b01,
        WAM_ST_FINISH = 2'b11
    } wam_state_e;

endpackage

// ### design/wam_cycle_timer.sv
// Down counter that marks the end of a fixed instruction time.
// Assumes a one-cycle start pulse while idle.
`timescale 1ns/1ns
`default_nettype none
module wam_cycle_timer (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [wam_pkg::CNT_W-1:0] i_cycles,
    output logic o_expired
);
    logic [wam_pkg::CNT_W-1:0] count_q;
    logic running_q;

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            count_q <= '0;
            running_q <= 1'b0;
        end
        else if (i_start)
        begin
            // Start edge, finish state and done register take the last three
            count_q <= i_cycles - wam_pkg::CNT_W'(3);
            running_q <= 1'b1;
        end
        else if (running_q)
        begin
            if (count_q == '0)
                running_q <= 1'b0;
            else
                count_q <= count_q - wam_pkg::CNT_W'(1);
        end
    end

    assign o_expired = running_q && (count_q == '0);
endmodule // wam_cycle_timer
`default_nettype wire

// ### design/wam_ea_former.sv
// Effective address formation for normal and extend modes.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module wam_ea_former (
    input wire logic i_extend,
    input wire logic i_fitted,
    input wire logic [14:0] i_pc,
    input wire logic [15:0] i_instr_word,
    input wire logic i_from_indirect,
    input wire logic [15:0] i_indirect_word,
    input wire logic [14:0] i_index_value,
    output logic [14:0] o_ea
);
    logic [14:0] direct_addr;
    logic [14:0] base_addr;
    logic [14:0] sum_addr;
    logic use_index;

    always_comb
    begin
        // Sector zero never sees the high page bit; others take it from the counter
        if (i_instr_word[wam_pkg::IW_SECTOR_BIT])
            direct_addr = {i_pc[14:wam_pkg::SECTOR_LSB],
                i_instr_word[wam_pkg::SECTOR_LSB-1:0]};
        else
            direct_addr = {6'h00, i_instr_word[wam_pkg::SECTOR_LSB-1:0]};
        if (!i_from_indirect)
            base_addr = direct_addr;
        else if (i_extend)
            base_addr = i_indirect_word[14:0];
        else
            base_addr = {i_pc[14], i_indirect_word[13:0]};
        // Extend mode: one index step, from the instruction only, applied last
        if (i_extend)
            use_index = i_instr_word[wam_pkg::IW_INDEX_BIT];
        else if (i_from_indirect)
            use_index = i_indirect_word[wam_pkg::IW_INDEX_BIT];
        else
            use_index = i_instr_word[wam_pkg::IW_INDEX_BIT];
        sum_addr = use_index ? 15'(base_addr + i_index_value) : base_addr;
        o_ea = i_fitted ? sum_addr : {1'b0, sum_addr[13:0]};
    end
endmodule // wam_ea_former
`default_nettype wire

// ### sim/wam_wide_addr_chk.sv
// Concurrent checks on the wide addressing block, bound to its top module.
// Assumes core strobes are one-cycle pulses and instructions wait for done.
`timescale 1ns/1ns
`default_nettype none
module wam_wide_addr_chk #(
    parameter logic [15:0] ENTER_CODE = 16'h0000,
    parameter logic [15:0] LEAVE_CODE = 16'h0000
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr_word,
    input wire logic i_int_taken,
    input wire logic i_master_clear,
    input wire logic i_pc_load,
    input wire logic [14:0] i_pc_value,
    input wire logic [15:0] i_ret_old_word,
    input wire logic i_ea_req,
    input wire logic i_ea_from_indirect,
    input wire logic [15:0] i_ea_indirect_word,
    input wire logic [14:0] o_pc,
    input wire logic o_pc_high_extension_bit,
    input wire logic o_extend_mode,
    input wire logic o_prior_mode_flag,
    input wire logic [14:0] o_ea,
    input wire logic o_memory_address_msb_line,
    input wire logic o_ea_valid,
    input wire logic [15:0] o_ret_store_word,
    input wire logic o_instr_done,
    input wire logic o_skip
);
    logic idle_q;
    wire logic take = i_instr_valid && idle_q;
    wire logic [15:0] w = i_instr_word;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Only decodes taken while idle are timed
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
            idle_q <= 1'b1;
        else if (take)
            idle_q <= 1'b0;
        else if (o_instr_done)
            idle_q <= 1'b1;
    end
    a_pc_load: assert property (i_pc_load |=> o_pc[13:0] == $past(i_pc_value[13:0])
        && o_pc_high_extension_bit == o_pc[14]) else $error("pc load mismatch");
    a_msb_line: assert property (i_ea_req && !i_ea_from_indirect && !w[14] |=>
        o_ea_valid && o_memory_address_msb_line == o_ea[14]
        && o_memory_address_msb_line == ($past(w[9]) && $past(o_pc_high_extension_bit)))
        else $error("msb line does not follow sector and counter");
    a_ext_indirect: assert property (i_ea_req && o_extend_mode && i_ea_from_indirect
        && !w[14] |=> o_ea_valid && o_ea[13:0] == $past(i_ea_indirect_word[13:0]))
        else $error("extend indirect address wrong");
    a_int_extend: assert property (i_int_taken |=> o_extend_mode)
        else $error("interrupt did not set extend");
    a_int_prior: assert property (i_int_taken |=> o_prior_mode_flag == $past(o_extend_mode))
        else $error("prior flag not captured");
    a_clear_prior: assert property (i_master_clear && !i_int_taken |=> !o_prior_mode_flag)
        else $error("master clear kept prior flag");
    a_store_keep: assert property (take && o_extend_mode && w[13:10] == 4'h8
        |=> o_ret_store_word == {$past(i_ret_old_word[15]), $past(o_pc)})
        else $error("store word wrong");
    a_enter_time: assert property (take && w == ENTER_CODE |=> o_extend_mode ##84 o_instr_done)
        else $error("enter timing wrong");
    a_leave_hold: assert property (take && w == LEAVE_CODE && o_extend_mode |=> o_extend_mode)
        else $error("leave acted before a jump");
    a_sense_skip: assert property (take && w[13:0] == 14'h3050
        |-> ##170 o_instr_done && o_skip == $past(o_prior_mode_flag, 170))
        else $error("sense timing or skip wrong");
endmodule // wam_wide_addr_chk

bind wam_wide_addr wam_wide_addr_chk #(.ENTER_CODE(ENTER_CODE), .LEAVE_CODE(LEAVE_CODE)) u_chk (
    .i_core_clk, .i_rst, .i_instr_valid, .i_instr_word, .i_int_taken, .i_master_clear,
    .i_pc_load, .i_pc_value, .i_ret_old_word, .i_ea_req, .i_ea_from_indirect,
    .i_ea_indirect_word, .o_pc, .o_pc_high_extension_bit, .o_extend_mode, .o_prior_mode_flag,
    .o_ea, .o_memory_address_msb_line, .o_ea_valid, .o_ret_store_word, .o_instr_done, .o_skip
);
`default_nettype wire

// ### sim/wam_core_mdl.sv
// Core-side model: issues decode and address strobes, supplies the target word.
// Assumes the bench pulses i_go or i_ea_go for one cycle at a time.
`timescale 1ns/1ns
`default_nettype none
module wam_core_mdl (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic i_ea_go,
    input wire logic [15:0] i_word,
    input wire logic [15:0] i_mem_word,
    input wire logic i_done,
    output logic o_valid,
    output logic o_ea_req,
    output logic [15:0] o_word,
    output logic [15:0] o_old_word,
    output logic o_busy,
    output logic [8:0] o_lat
);
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_valid <= 1'b0;
            o_ea_req <= 1'b0;
            o_word <= 16'h0000;
            o_old_word <= 16'h0000;
            o_busy <= 1'b0;
            o_lat <= 9'h000;
        end
        else
        begin
            o_valid <= i_go;
            o_ea_req <= i_ea_go;
            if (i_go || i_ea_go)
                o_word <= i_word;
            // Target word is only valid with the strobe; scramble it afterwards
            o_old_word <= i_go ? i_mem_word : ~o_old_word;
            if (o_valid)
            begin
                o_busy <= 1'b1;
                o_lat <= 9'h001;
            end
            else if (o_busy && i_done)
                o_busy <= 1'b0;
            else if (o_busy)
                o_lat <= o_lat + 9'h001;
        end
    end
endmodule // wam_core_mdl
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the wide addressing block.
// Assumes the core model in wam_core_mdl and a 50 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam int ENTER_LAT = wam_pkg::ENTER_TIME_NS * wam_pkg::CLK_MHZ / 1000;
    localparam int SENSE_LAT = wam_pkg::SENSE_TIME_NS * wam_pkg::CLK_MHZ / 1000;
    logic clk, rst, av_rd, av_wr, go, ea_go, from_ind, skip_seen;
    logic [3:0] av_addr, strb;
    logic [31:0] av_wd, q;
    logic [15:0] word, mem, iwd;
    logic [14:0] idx, pc_val;
    wire logic [31:0] rdata;
    wire logic [15:0] m_word, m_old, store_w;
    wire logic [14:0] pc, ea;
    wire logic [8:0] lat;
    wire logic waitreq, m_valid, m_ea_req, busy, pc_hi, ext, prior, msb, ea_v, done, skip;
    int n_fail = 0;
    int cmp_count = 0;
    wam_core_mdl u_core (.i_core_clk(clk), .i_rst(rst), .i_go(go), .i_ea_go(ea_go),
        .i_word(word), .i_mem_word(mem), .i_done(done), .o_valid(m_valid), .o_ea_req(m_ea_req),
        .o_word(m_word), .o_old_word(m_old), .o_busy(busy), .o_lat(lat));
    wam_wide_addr u_dut (.i_core_clk(clk), .i_rst(rst), .i_avs_address(av_addr),
        .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_instr_valid(m_valid),
        .i_instr_word(m_word), .i_int_taken(strb[0]), .i_master_clear(strb[1]),
        .i_pc_load(strb[2]), .i_pc_value(pc_val), .i_pc_incr(strb[3]), .i_ret_old_word(m_old),
        .i_ea_req(m_ea_req), .i_ea_from_indirect(from_ind), .i_ea_indirect_word(iwd),
        .i_ea_index_value(idx), .o_pc(pc), .o_pc_high_extension_bit(pc_hi),
        .o_extend_mode(ext), .o_prior_mode_flag(prior), .o_ea(ea),
        .o_memory_address_msb_line(msb), .o_ea_valid(ea_v), .o_ret_store_word(store_w),
        .o_instr_done(done), .o_skip(skip));
    always #10 clk = ~clk;
    // Skip is a one-cycle pulse; keep it for the check after completion
    always @(posedge clk)
        if (done)
            skip_seen <= skip;
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic hang(input int i, input int lim);
        if (i == lim)
        begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        av_addr <= a;
        av_rd <= !wr;
        av_wr <= wr;
        av_wd <= d;
        // Waitrequest is sampled at the rising edge; read data is taken there too
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (!waitreq)
                break;
        end
        hang(i, 20);
        q = rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
        avs(1'b0, a, 32'h0000_0000);
        chk("register read", exp, q);
    endtask
    task automatic pulse(input int k);
        @(posedge clk);
        strb[k] <= 1'b1;
        @(posedge clk);
        strb <= 4'h0;
        @(negedge clk);
    endtask
    task automatic ldpc(input logic [14:0] v);
        @(posedge clk);
        pc_val <= v;
        pulse(2);
    endtask
    task automatic run(input logic [15:0] w, input logic [15:0] m, input int n);
        int i;
        @(posedge clk);
        go <= 1'b1;
        word <= w;
        mem <= m;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 400; i++)
        begin
            @(negedge clk);
            if (!busy)
                break;
        end
        hang(i, 400);
        chk("latency", n, {23'h0, lat});
    endtask
    task automatic ea_chk(input logic [15:0] w, input logic ind, input logic [15:0] iw,
        input logic [14:0] ix, input logic [14:0] exp);
        int i;
        @(posedge clk);
        ea_go <= 1'b1;
        word <= w;
        from_ind <= ind;
        iwd <= iw;
        idx <= ix;
        @(posedge clk);
        ea_go <= 1'b0;
        for (i = 0; i < 10; i++)
        begin
            @(negedge clk);
            if (ea_v)
                break;
        end
        hang(i, 10);
        chk("address", exp, ea);
        chk("msb line", exp[14], msb);
    endtask
    initial
    begin
        {clk, av_rd, av_wr, go, ea_go, from_ind, skip_seen} = 7'h00;
        {av_addr, strb, av_wd, word, mem, iwd, idx, pc_val} = '0;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        reg_rd(wam_pkg::OFS_CTRL, {31'h0, wam_pkg::CTRL_FITTED_RST});
        reg_rd(wam_pkg::OFS_STATUS, 32'h0000_0000);
        reg_rd(4'hc, 32'h0000_0000);
        avs(1'b1, wam_pkg::OFS_CTRL, 32'h0000_0000);
        reg_rd(wam_pkg::OFS_CTRL, 32'h0000_0000);
        ldpc(15'h7fff);
        chk("pc unfitted", 32'h0000_3fff, pc);
        avs(1'b1, wam_pkg::OFS_CTRL, 32'h0000_0001);
        ldpc(15'h49ff);
        pulse(3);
        chk("pc high bit", 32'h1, pc_hi);
        avs(1'b1, wam_pkg::OFS_PC, 32'h0000_0000);
        reg_rd(wam_pkg::OFS_PC, 32'h0000_4a00);
        ea_chk(16'h0205, 1'b0, 16'h0000, 15'h0000, 15'h4a05);
        ea_chk(16'h0005, 1'b0, 16'h0000, 15'h0000, 15'h0005);
        run(wam_pkg::ENTER_CODE_DEF, 16'h0000, ENTER_LAT);
        chk("extend", 32'h1, ext);
        ea_chk(16'h4000, 1'b1, 16'h4123, 15'h0010, 15'h4133);
        ea_chk(16'h0000, 1'b1, 16'h4123, 15'h0010, 15'h4123);
        run(16'h2000, 16'h8000, 2);
        chk("store word", 32'h0000_ca00, store_w);
        pulse(0);
        chk("prior", 32'h1, prior);
        run(16'h3050, 16'h0000, SENSE_LAT);
        chk("skip", 32'h1, skip_seen);
        run(wam_pkg::LEAVE_CODE_DEF, 16'h0000, 2);
        reg_rd(wam_pkg::OFS_STATUS, 32'h0000_0007);
        run(16'h2000, 16'h0000, 2);
        chk("store word", 32'h0000_4a00, store_w);
        chk("extend", 32'h1, ext);
        run(16'h0400, 16'h0000, 2);
        chk("extend", 32'h0, ext);
        pulse(0);
        chk("prior", 32'h0, prior);
        chk("extend", 32'h1, ext);
        pulse(0);
        chk("prior", 32'h1, prior);
        pulse(1);
        chk("prior", 32'h0, prior);
        chk("extend", 32'h1, ext);
        run(16'h3050, 16'h0000, SENSE_LAT);
        chk("skip", 32'h0, skip_seen);
        wrap_up();
    end
endmodule // tb
`default_nettype wire
